// ==== verilog/fpd_params.svh ====
`ifndef FPD_PARAMS_SVH
`define FPD_PARAMS_SVH

// Primary opcode values
`define FPD_OP_CALL      6'h00
`define FPD_OP_VRES_LO   6'h01
`define FPD_OP_VRES_HI   6'h07
`define FPD_OP_INT_ARITH 6'h10
`define FPD_OP_INT_LOGIC 6'h11
`define FPD_OP_INT_SHIFT 6'h12
`define FPD_OP_INT_MUL   6'h13
`define FPD_OP_ITOF      6'h14
`define FPD_OP_LEGACY    6'h15
`define FPD_OP_IEEE      6'h16
`define FPD_OP_INDEP     6'h17
`define FPD_OP_MISC      6'h18
`define FPD_OP_FW19      6'h19
`define FPD_OP_JUMP      6'h1A
`define FPD_OP_FW1B      6'h1B
`define FPD_OP_FTOI      6'h1C
`define FPD_OP_FW1D      6'h1D
`define FPD_OP_FW1E      6'h1E
`define FPD_OP_FW1F      6'h1F

// Instruction field positions
`define FPD_OPC_HI 31
`define FPD_OPC_LO 26
`define FPD_FN_HI  15
`define FPD_FN_LO  5
`define FPD_CALL_HI 25

// Legacy qualifier bits inside the function code
`define FPD_QB_SOFT  10
`define FPD_QB_UNDER 8
`define FPD_QB_NOCHP 7
`define FPD_QB_RSVD  9
`define FPD_LB_HI    6

// Legacy base codes (low byte, unchopped form)
`define FPD_LB_SADD  8'h80
`define FPD_LB_SSUB  8'h81
`define FPD_LB_SMUL  8'h82
`define FPD_LB_SDIV  8'h83
`define FPD_LB_SROOT 8'h8A
`define FPD_LB_DTOG  8'h9E
`define FPD_LB_DADD  8'hA0
`define FPD_LB_DSUB  8'hA1
`define FPD_LB_DMUL  8'hA2
`define FPD_LB_DDIV  8'hA3
`define FPD_LB_CEQ   8'hA5
`define FPD_LB_CLT   8'hA6
`define FPD_LB_CLE   8'hA7
`define FPD_LB_DROOT 8'hAA
`define FPD_LB_GTOF  8'hAC
`define FPD_LB_GTOD  8'hAD
`define FPD_LB_GTOQ  8'hAF
`define FPD_LB_QTOF  8'hBC
`define FPD_LB_QTOG  8'hBE

// Independent group codes
`define FPD_IF_COPY   11'h020
`define FPD_IF_COPYN  11'h021
`define FPD_IF_COPYE  11'h022
`define FPD_IF_LTOQ   11'h010
`define FPD_IF_QTOL   11'h030
`define FPD_IF_QTOLV  11'h130
`define FPD_IF_QTOLSV 11'h530
`define FPD_IF_MVEQ   11'h02A
`define FPD_IF_MVLT   11'h02C
`define FPD_IF_MVGE   11'h02D
`define FPD_IF_MVLE   11'h02E
`define FPD_IF_MVGT   11'h02F
`define FPD_IF_RDFC   11'h025
`define FPD_IF_WRFC   11'h024

// Call function codes
`define FPD_CF_HALT  26'h0000000
`define FPD_CF_DRAIN 26'h0000002
`define FPD_CF_BARRIER 26'h0000086

`endif

// ==== verilog/fpd_pkg.sv ====
package fpd_pkg;

  typedef enum logic [3:0] {
    CLS_CALL, CLS_VENDOR_RES, CLS_FW_RES, CLS_INT_ARITH, CLS_INT_LOGIC, CLS_INT_SHIFT,
    CLS_INT_MUL, CLS_ITOF, CLS_LEGACY_FP, CLS_IEEE_FP, CLS_INDEP_FP, CLS_MISC, CLS_JUMP,
    CLS_FTOI, CLS_OTHER
  } fpd_class_t;

  typedef enum logic [4:0] {
    OP_NONE, OP_LEG_SADD, OP_LEG_SSUB, OP_LEG_SMUL, OP_LEG_SDIV, OP_LEG_SROOT,
    OP_LEG_DADD, OP_LEG_DSUB, OP_LEG_DMUL, OP_LEG_DDIV, OP_LEG_DROOT,
    OP_LEG_CEQ, OP_LEG_CLT, OP_LEG_CLE, OP_CVT_DTOG, OP_CVT_GTOD, OP_CVT_GTOF,
    OP_CVT_GTOQ, OP_CVT_QTOF, OP_CVT_QTOG, OP_COPY_SIGN, OP_COPY_NEG, OP_COPY_EXP,
    OP_CVT_LTOQ, OP_CVT_QTOL, OP_MV_EQ, OP_MV_LT, OP_MV_GE, OP_MV_LE, OP_MV_GT,
    OP_RD_FCTL, OP_WR_FCTL
  } fpd_op_t;

  typedef enum logic [1:0] {
    CALL_NONE, CALL_HALT, CALL_DRAIN, CALL_BARRIER
  } fpd_call_t;

  typedef struct packed {
    logic chopped;
    logic underflow;
    logic overflow;
    logic software;
  } fpd_qual_t;

  typedef struct packed {
    logic valid;
    fpd_class_t cls;
    fpd_op_t op;
    fpd_qual_t qual;
    fpd_call_t call;
    logic privileged;
    logic illegal;
  } fpd_dec_t;

endpackage : fpd_pkg

// ==== verilog/fpd_decoder.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "fpd_params.svh"

module fpd_decoder
  import fpd_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // From fetch
  input wire logic instrValid,
  input wire logic [31:0] instrWord,
  // To execution and trap logic
  output fpd_dec_t decOut
);

  // Legacy operation from the unchopped low byte
  function automatic fpd_op_t legacyOp(input logic [7:0] lb);
    case (lb)
      `FPD_LB_SADD: legacyOp = OP_LEG_SADD;
      `FPD_LB_SSUB: legacyOp = OP_LEG_SSUB;
      `FPD_LB_SMUL: legacyOp = OP_LEG_SMUL;
      `FPD_LB_SDIV: legacyOp = OP_LEG_SDIV;
      `FPD_LB_SROOT: legacyOp = OP_LEG_SROOT;
      `FPD_LB_DTOG: legacyOp = OP_CVT_DTOG;
      `FPD_LB_DADD: legacyOp = OP_LEG_DADD;
      `FPD_LB_DSUB: legacyOp = OP_LEG_DSUB;
      `FPD_LB_DMUL: legacyOp = OP_LEG_DMUL;
      `FPD_LB_DDIV: legacyOp = OP_LEG_DDIV;
      `FPD_LB_CEQ: legacyOp = OP_LEG_CEQ;
      `FPD_LB_CLT: legacyOp = OP_LEG_CLT;
      `FPD_LB_CLE: legacyOp = OP_LEG_CLE;
      `FPD_LB_DROOT: legacyOp = OP_LEG_DROOT;
      `FPD_LB_GTOF: legacyOp = OP_CVT_GTOF;
      `FPD_LB_GTOD: legacyOp = OP_CVT_GTOD;
      `FPD_LB_GTOQ: legacyOp = OP_CVT_GTOQ;
      `FPD_LB_QTOF: legacyOp = OP_CVT_QTOF;
      `FPD_LB_QTOG: legacyOp = OP_CVT_QTOG;
      default: legacyOp = OP_NONE;
    endcase
  endfunction : legacyOp

  logic [5:0] opc;
  logic [10:0] fn;
  logic [7:0] lowByte;
  logic softQ;
  logic underQ;
  logic chopQ;
  fpd_class_t clsD;
  fpd_op_t opD;
  fpd_qual_t qualD;
  fpd_call_t callD;
  logic privD;
  logic illD;
  fpd_dec_t dec_q;

  assign opc = instrWord[`FPD_OPC_HI:`FPD_OPC_LO];
  assign fn = instrWord[`FPD_FN_HI:`FPD_FN_LO];
  assign softQ = fn[`FPD_QB_SOFT];
  assign underQ = fn[`FPD_QB_UNDER];
  assign chopQ = ~fn[`FPD_QB_NOCHP];
  // Restore the unchopped code so one table serves both forms
  assign lowByte = {1'b1, fn[`FPD_LB_HI:0]};

  // Primary opcode classification
  always_comb begin
    clsD = CLS_OTHER;
    case (opc)
      `FPD_OP_CALL: clsD = CLS_CALL;
      `FPD_OP_INT_ARITH: clsD = CLS_INT_ARITH;
      `FPD_OP_INT_LOGIC: clsD = CLS_INT_LOGIC;
      `FPD_OP_INT_SHIFT: clsD = CLS_INT_SHIFT;
      `FPD_OP_INT_MUL: clsD = CLS_INT_MUL;
      `FPD_OP_ITOF: clsD = CLS_ITOF;
      `FPD_OP_LEGACY: clsD = CLS_LEGACY_FP;
      `FPD_OP_IEEE: clsD = CLS_IEEE_FP;
      `FPD_OP_INDEP: clsD = CLS_INDEP_FP;
      `FPD_OP_MISC: clsD = CLS_MISC;
      `FPD_OP_JUMP: clsD = CLS_JUMP;
      `FPD_OP_FTOI: clsD = CLS_FTOI;
      `FPD_OP_FW19, `FPD_OP_FW1B, `FPD_OP_FW1D, `FPD_OP_FW1E, `FPD_OP_FW1F: clsD = CLS_FW_RES;
      default: begin
        if (opc >= `FPD_OP_VRES_LO && opc <= `FPD_OP_VRES_HI) begin
          clsD = CLS_VENDOR_RES;
        end
      end
    endcase
  end

  // Operation, qualifier and legality decode
  always_comb begin
    opD = OP_NONE;
    qualD = '0;
    callD = CALL_NONE;
    privD = 1'b0;
    illD = 1'b0;
    case (clsD)
      CLS_VENDOR_RES, CLS_FW_RES: begin
        illD = 1'b1;
      end
      CLS_CALL: begin
        case (instrWord[`FPD_CALL_HI:0])
          `FPD_CF_HALT: begin
            callD = CALL_HALT;
            privD = 1'b1;
          end
          `FPD_CF_DRAIN: begin
            callD = CALL_DRAIN;
            privD = 1'b1;
          end
          `FPD_CF_BARRIER: callD = CALL_BARRIER;
          default: callD = CALL_NONE;
        endcase
      end
      CLS_LEGACY_FP: begin
        // Reserved bit is never set in a legacy code
        opD = fn[`FPD_QB_RSVD] ? OP_NONE : legacyOp(lowByte);
        qualD.software = softQ;
        qualD.chopped = chopQ;
        case (opD)
          OP_LEG_CEQ, OP_LEG_CLT, OP_LEG_CLE: begin
            if (chopQ || underQ) begin
              opD = OP_NONE;
            end
          end
          OP_CVT_QTOF, OP_CVT_QTOG: begin
            if (softQ || underQ) begin
              opD = OP_NONE;
            end
          end
          OP_CVT_GTOQ: qualD.overflow = underQ;
          OP_NONE: opD = OP_NONE;
          default: qualD.underflow = underQ;
        endcase
        illD = (opD == OP_NONE);
        if (illD) begin
          qualD = '0;
        end
      end
      CLS_INDEP_FP: begin
        case (fn)
          `FPD_IF_COPY: opD = OP_COPY_SIGN;
          `FPD_IF_COPYN: opD = OP_COPY_NEG;
          `FPD_IF_COPYE: opD = OP_COPY_EXP;
          `FPD_IF_LTOQ: opD = OP_CVT_LTOQ;
          `FPD_IF_QTOL: opD = OP_CVT_QTOL;
          `FPD_IF_QTOLV: begin
            opD = OP_CVT_QTOL;
            qualD.overflow = 1'b1;
          end
          `FPD_IF_QTOLSV: begin
            opD = OP_CVT_QTOL;
            qualD.overflow = 1'b1;
            qualD.software = 1'b1;
          end
          `FPD_IF_MVEQ: opD = OP_MV_EQ;
          `FPD_IF_MVLT: opD = OP_MV_LT;
          `FPD_IF_MVGE: opD = OP_MV_GE;
          `FPD_IF_MVLE: opD = OP_MV_LE;
          `FPD_IF_MVGT: opD = OP_MV_GT;
          `FPD_IF_RDFC: opD = OP_RD_FCTL;
          `FPD_IF_WRFC: opD = OP_WR_FCTL;
          default: illD = 1'b1;
        endcase
      end
      default: opD = OP_NONE;
    endcase
  end

  // Registered decode result, one cycle after the word
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dec_q <= '0;
    end else begin
      dec_q.valid <= instrValid;
      dec_q.cls <= clsD;
      dec_q.op <= opD;
      dec_q.qual <= qualD;
      dec_q.call <= callD;
      dec_q.privileged <= privD;
      dec_q.illegal <= instrValid & illD;
    end
  end

  assign decOut = dec_q;

  a_legacy_group: assert property (@(posedge clk) disable iff (sys_rst)
    instrValid && opc == `FPD_OP_LEGACY |=> decOut.cls == CLS_LEGACY_FP)
    else $error("legacy opcode not classed");
  a_add_chop_under: assert property (@(posedge clk) disable iff (sys_rst)
    instrValid && opc == `FPD_OP_LEGACY && fn == 11'h500 |=>
      decOut.op == OP_LEG_SADD && decOut.qual == 4'hD && !decOut.illegal)
    else $error("single add software underflow chopped wrong");
  a_add_plain: assert property (@(posedge clk) disable iff (sys_rst)
    instrValid && opc == `FPD_OP_LEGACY && fn == 11'h080 |=> decOut.op == OP_LEG_SADD && decOut.qual == 4'h0)
    else $error("single add unqualified wrong");
  a_mul_under: assert property (@(posedge clk) disable iff (sys_rst)
    instrValid && opc == `FPD_OP_LEGACY && fn == 11'h182 |=> decOut.op == OP_LEG_SMUL && decOut.qual.underflow)
    else $error("single multiply underflow wrong");
  a_sub_plain: assert property (@(posedge clk) disable iff (sys_rst)
    instrValid && opc == `FPD_OP_LEGACY && fn == 11'h081 |=> decOut.op == OP_LEG_SSUB && decOut.qual == 4'h0)
    else $error("single subtract unqualified wrong");
  a_div_full_qual: assert property (@(posedge clk) disable iff (sys_rst)
    instrValid && opc == `FPD_OP_LEGACY && fn == 11'h523 |=> decOut.op == OP_LEG_DDIV && decOut.qual == 4'hD)
    else $error("double divide qualifiers wrong");
  a_root_decode: assert property (@(posedge clk) disable iff (sys_rst)
    instrValid && opc == `FPD_OP_LEGACY && fn == 11'h02A |=> decOut.op == OP_LEG_DROOT && decOut.qual.chopped)
    else $error("double root chopped wrong");
  a_root_single: assert property (@(posedge clk) disable iff (sys_rst)
    instrValid && opc == `FPD_OP_LEGACY && fn == 11'h08A |=> decOut.op == OP_LEG_SROOT && decOut.qual == 4'h0)
    else $error("single root unqualified wrong");
  a_compare_qual: assert property (@(posedge clk) disable iff (sys_rst)
    instrValid && opc == `FPD_OP_LEGACY && fn == 11'h025 |=> decOut.illegal)
    else $error("chopped compare not illegal");
  a_compare_soft: assert property (@(posedge clk) disable iff (sys_rst)
    instrValid && opc == `FPD_OP_LEGACY && fn == 11'h4A7 |=>
      decOut.op == OP_LEG_CLE && decOut.qual == 4'h1 && !decOut.illegal)
    else $error("software compare wrong");
  a_cvt_gd: assert property (@(posedge clk) disable iff (sys_rst)
    instrValid && opc == `FPD_OP_LEGACY && fn == 11'h52D |=> decOut.op == OP_CVT_GTOD)
    else $error("g to d conversion wrong");
  a_cvt_dg: assert property (@(posedge clk) disable iff (sys_rst)
    instrValid && opc == `FPD_OP_LEGACY && fn == 11'h19E |=> decOut.op == OP_CVT_DTOG && decOut.qual == 4'h4)
    else $error("d to g underflow conversion wrong");
  a_quad_single: assert property (@(posedge clk) disable iff (sys_rst)
    instrValid && opc == `FPD_OP_LEGACY && fn == 11'h4BC |=> decOut.illegal)
    else $error("software quad conversion not illegal");
  a_quad_chop: assert property (@(posedge clk) disable iff (sys_rst)
    instrValid && opc == `FPD_OP_LEGACY && fn == 11'h03E |=>
      decOut.op == OP_CVT_QTOG && decOut.qual == 4'h8 && !decOut.illegal)
    else $error("chopped quad conversion wrong");
  a_gtoq_ovf: assert property (@(posedge clk) disable iff (sys_rst)
    instrValid && opc == `FPD_OP_LEGACY && fn == 11'h12F |=>
      decOut.op == OP_CVT_GTOQ && decOut.qual.overflow && !decOut.qual.underflow)
    else $error("overflow qualifier wrong");
  a_indep_group: assert property (@(posedge clk) disable iff (sys_rst)
    instrValid && opc == `FPD_OP_INDEP |=> decOut.cls == CLS_INDEP_FP)
    else $error("independent opcode not classed");
  a_copy_negated: assert property (@(posedge clk) disable iff (sys_rst)
    instrValid && opc == `FPD_OP_INDEP && fn == `FPD_IF_COPYN |=> decOut.op == OP_COPY_NEG)
    else $error("negated copy sign wrong");
  a_qtol_sv: assert property (@(posedge clk) disable iff (sys_rst)
    instrValid && opc == `FPD_OP_INDEP && fn == `FPD_IF_QTOLSV |=> decOut.op == OP_CVT_QTOL && decOut.qual == 4'h3)
    else $error("quad to long software overflow wrong");
  a_ltoq_plain: assert property (@(posedge clk) disable iff (sys_rst)
    instrValid && opc == `FPD_OP_INDEP && fn == `FPD_IF_LTOQ |=> decOut.op == OP_CVT_LTOQ)
    else $error("long to quad conversion wrong");
  a_cond_move: assert property (@(posedge clk) disable iff (sys_rst)
    instrValid && opc == `FPD_OP_INDEP && fn == `FPD_IF_MVGT |=> decOut.op == OP_MV_GT)
    else $error("move if greater wrong");
  a_fctl_write: assert property (@(posedge clk) disable iff (sys_rst)
    instrValid && opc == `FPD_OP_INDEP && fn == `FPD_IF_WRFC |=> decOut.op == OP_WR_FCTL)
    else $error("control register write wrong");
  a_other_class: assert property (@(posedge clk) disable iff (sys_rst)
    instrValid && opc == 6'h3F |=> decOut.cls == CLS_OTHER && !decOut.illegal)
    else $error("top opcode class wrong");
  a_int_groups: assert property (@(posedge clk) disable iff (sys_rst)
    instrValid && opc == `FPD_OP_INT_SHIFT |=> decOut.cls == CLS_INT_SHIFT)
    else $error("shift group wrong");
  a_ieee_class: assert property (@(posedge clk) disable iff (sys_rst)
    instrValid && opc == `FPD_OP_IEEE |=> decOut.cls == CLS_IEEE_FP && decOut.op == OP_NONE && !decOut.illegal)
    else $error("ieee group class wrong");
  a_jump_class: assert property (@(posedge clk) disable iff (sys_rst)
    instrValid && opc == `FPD_OP_JUMP |=> decOut.cls == CLS_JUMP)
    else $error("jump group class wrong");
  a_fw_reserved: assert property (@(posedge clk) disable iff (sys_rst)
    instrValid && (opc == `FPD_OP_FW19 || opc == `FPD_OP_FW1E) |=> decOut.cls == CLS_FW_RES && decOut.illegal)
    else $error("firmware opcode not reserved");
  a_vendor_res: assert property (@(posedge clk) disable iff (sys_rst)
    instrValid && opc >= `FPD_OP_VRES_LO && opc <= `FPD_OP_VRES_HI |=> decOut.cls == CLS_VENDOR_RES && decOut.illegal)
    else $error("vendor opcode not reserved");
  a_call_field: assert property (@(posedge clk) disable iff (sys_rst)
    instrValid && opc == `FPD_OP_CALL && instrWord[`FPD_CALL_HI:0] == 26'h2000086 |=> decOut.call == CALL_NONE)
    else $error("call field not fully decoded");
  a_call_priv: assert property (@(posedge clk) disable iff (sys_rst)
    instrValid && opc == `FPD_OP_CALL && instrWord[`FPD_CALL_HI:0] == `FPD_CF_BARRIER |=>
      decOut.call == CALL_BARRIER && !decOut.privileged)
    else $error("barrier call decode wrong");
  a_ill_gated: assert property (@(posedge clk) disable iff (sys_rst)
    !instrValid |=> !decOut.illegal)
    else $error("illegal flag without valid word");
  a_unlisted_fn: assert property (@(posedge clk) disable iff (sys_rst)
    instrValid && opc == `FPD_OP_LEGACY && fn[`FPD_QB_RSVD] |=> decOut.illegal && decOut.op == OP_NONE)
    else $error("unlisted legacy code not illegal");

endmodule : fpd_decoder
`default_nettype wire

// ==== tb/fpd_fetch_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module fpd_fetch_model (
  // Clock
  input wire logic clk,
  // To decoder
  output logic instrValid,
  output logic [31:0] instrWord
);
  initial begin
    instrValid = 1'b0;
    instrWord = 32'h00000000;
  end

  // Idle slots show the inverted current word, so two idles in a row bring back a stale copy
  task automatic send(input logic v, input logic [31:0] w);
    @(posedge clk);
    instrValid <= v;
    instrWord <= v ? w : ~instrWord;
  endtask : send
endmodule : fpd_fetch_model
`default_nettype wire

// ==== tb/test_fp_and_primary_opcode_decoder.sv ====
`timescale 1ns/1ns
`default_nettype none
module test_fp_and_primary_opcode_decoder
  import fpd_pkg::*;
;
  logic clk;
  logic sys_rst;
  logic instrValid;
  logic [31:0] instrWord;
  fpd_dec_t decOut;
  int n_fail = 0;
  int compares = 0;

  fpd_fetch_model fetch (.clk(clk), .instrValid(instrValid), .instrWord(instrWord));
  fpd_decoder DUT (.clk(clk), .sys_rst(sys_rst), .instrValid(instrValid), .instrWord(instrWord), .decOut(decOut));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic report_and_stop;
    $display("Counts: %0d compares, %0d mismatches", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : report_and_stop

  // Full compare also covers op, call and privilege
  task automatic check(input logic [31:0] w, input fpd_dec_t e, input bit full);
    compares++;
    if (decOut.valid !== e.valid || decOut.cls !== e.cls || decOut.illegal !== e.illegal || decOut.qual !== e.qual
        || (full && (decOut.op !== e.op || decOut.call !== e.call || decOut.privileged !== e.privileged))) begin
      n_fail++;
      $display("wrong value at %0t: word %h gave %h, expected %h", $time, w, decOut, e);
    end
  endtask : check

  function automatic fpd_dec_t mk(fpd_class_t c, fpd_op_t o, logic [3:0] q, logic ill);
    fpd_dec_t e;
    e = '0;
    e.valid = 1'b1;
    e.cls = c;
    e.op = o;
    e.qual = q;
    e.illegal = ill;
    return e;
  endfunction : mk

  task automatic one(input logic [31:0] w, input fpd_dec_t e, input bit full);
    fetch.send(1'b1, w);
    @(posedge clk);
    #1 check(w, e, full);
  endtask : one

  // v: bit2 software, bit1 underflow or overflow, bit0 chopped
  task automatic leg(input logic [7:0] b, input fpd_op_t o, input logic [2:0] v, input logic ovf, input logic ill);
    logic [31:0] w;
    w = {6'h15, 10'h000, v[2], 1'b0, v[1], ~v[0], b[6:0], 5'h00};
    if (ill) one(w, mk(CLS_LEGACY_FP, OP_NONE, 4'h0, 1'b1), 1'b0);
    else one(w, mk(CLS_LEGACY_FP, o, {v[0], v[1] & ~ovf, v[1] & ovf, v[2]}, 1'b0), 1'b1);
  endtask : leg

  task automatic t_legacy_full;
    logic [7:0] bs [13] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'h8A, 8'hA0, 8'hA1, 8'hA2, 8'hA3, 8'hAA, 8'h9E, 8'hAD, 8'hAC};
    fpd_op_t os [13] = '{OP_LEG_SADD, OP_LEG_SSUB, OP_LEG_SMUL, OP_LEG_SDIV, OP_LEG_SROOT, OP_LEG_DADD,
      OP_LEG_DSUB, OP_LEG_DMUL, OP_LEG_DDIV, OP_LEG_DROOT, OP_CVT_DTOG, OP_CVT_GTOD, OP_CVT_GTOF};
    for (int i = 0; i < 13; i++) begin
      for (int v = 0; v < 8; v++) begin
        leg(bs[i], os[i], 3'(v), 1'b0, 1'b0);
      end
    end
    $display("legacy eight-qualifier set done");
  endtask : t_legacy_full

  task automatic t_legacy_limited;
    for (int v = 0; v < 8; v++) begin
      leg(8'hA5, OP_LEG_CEQ, 3'(v), 1'b0, v[1:0] != 0);
      leg(8'hA6, OP_LEG_CLT, 3'(v), 1'b0, v[1:0] != 0);
      leg(8'hA7, OP_LEG_CLE, 3'(v), 1'b0, v[1:0] != 0);
      leg(8'hBC, OP_CVT_QTOF, 3'(v), 1'b0, v[2:1] != 0);
      leg(8'hBE, OP_CVT_QTOG, 3'(v), 1'b0, v[2:1] != 0);
      leg(8'hAF, OP_CVT_GTOQ, 3'(v), 1'b1, 1'b0);
      leg(8'h84, OP_NONE, 3'(v), 1'b0, 1'b1);
    end
    one({6'h15, 10'h000, 11'h280, 5'h00}, mk(CLS_LEGACY_FP, OP_NONE, 4'h0, 1'b1), 1'b0);
    $display("legacy restricted qualifiers done");
  endtask : t_legacy_limited

  task automatic t_indep;
    logic [10:0] fs [16] = '{11'h020, 11'h021, 11'h022, 11'h010, 11'h030, 11'h130, 11'h530, 11'h02A,
      11'h02C, 11'h02D, 11'h02E, 11'h02F, 11'h025, 11'h024, 11'h031, 11'h230};
    fpd_op_t os [16] = '{OP_COPY_SIGN, OP_COPY_NEG, OP_COPY_EXP, OP_CVT_LTOQ, OP_CVT_QTOL, OP_CVT_QTOL, OP_CVT_QTOL,
      OP_MV_EQ, OP_MV_LT, OP_MV_GE, OP_MV_LE, OP_MV_GT, OP_RD_FCTL, OP_WR_FCTL, OP_NONE, OP_NONE};
    logic [3:0] q;
    for (int i = 0; i < 16; i++) begin
      q = (i == 5) ? 4'h2 : (i == 6) ? 4'h3 : 4'h0;
      one({6'h17, 10'h000, fs[i], 5'h00}, mk(CLS_INDEP_FP, os[i], q, i >= 14), i < 14);
    end
    $display("independent group done");
  endtask : t_indep

  task automatic t_classes;
    logic [5:0] oc;
    fpd_class_t c;
    for (int o = 0; o < 64; o++) begin
      oc = 6'(o);
      case (oc)
        6'h00: c = CLS_CALL;
        6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h07: c = CLS_VENDOR_RES;
        6'h10: c = CLS_INT_ARITH;
        6'h11: c = CLS_INT_LOGIC;
        6'h12: c = CLS_INT_SHIFT;
        6'h13: c = CLS_INT_MUL;
        6'h14: c = CLS_ITOF;
        6'h16: c = CLS_IEEE_FP;
        6'h18: c = CLS_MISC;
        6'h1A: c = CLS_JUMP;
        6'h1C: c = CLS_FTOI;
        6'h19, 6'h1B, 6'h1D, 6'h1E, 6'h1F: c = CLS_FW_RES;
        default: c = CLS_OTHER;
      endcase
      if (oc != 6'h15 && oc != 6'h17) begin
        one({oc, 26'h3FFFFFF}, mk(c, OP_NONE, 4'h0, c == CLS_VENDOR_RES || c == CLS_FW_RES), 1'b1);
      end
    end
    $display("opcode classes done");
  endtask : t_classes

  task automatic t_calls;
    logic [25:0] fs [4] = '{26'h0000000, 26'h0000002, 26'h0000086, 26'h2000086};
    fpd_call_t cs [4] = '{CALL_HALT, CALL_DRAIN, CALL_BARRIER, CALL_NONE};
    fpd_dec_t e;
    for (int i = 0; i < 4; i++) begin
      e = mk(CLS_CALL, OP_NONE, 4'h0, 1'b0);
      e.call = cs[i];
      e.privileged = i < 2;
      one({6'h00, fs[i]}, e, 1'b1);
    end
    $display("firmware calls done");
  endtask : t_calls

  // Back-to-back words, an idle slot, then reset in mid-run
  task automatic t_pipe;
    fpd_dec_t e;
    fetch.send(1'b1, {6'h15, 10'h000, 11'h523, 5'h00});
    fetch.send(1'b1, {6'h02, 26'h0000000});
    #1 check({6'h15, 10'h000, 11'h523, 5'h00}, mk(CLS_LEGACY_FP, OP_LEG_DDIV, 4'hD, 1'b0), 1'b1);
    @(posedge clk);
    #1 check({6'h02, 26'h0000000}, mk(CLS_VENDOR_RES, OP_NONE, 4'h0, 1'b1), 1'b1);
    fetch.send(1'b0, 32'h00000000);
    @(posedge clk);
    e = mk(CLS_OTHER, OP_NONE, 4'h0, 1'b0);
    e.valid = 1'b0;
    #1 check(32'hF7FFFFFF, e, 1'b0);
    fetch.send(1'b1, {6'h1B, 26'h0000000});
    sys_rst <= 1'b1;
    @(posedge clk);
    #1 check({6'h1B, 26'h0000000}, '0, 1'b1);
    @(posedge clk);
    sys_rst <= 1'b0;
    one({6'h1B, 26'h0000000}, mk(CLS_FW_RES, OP_NONE, 4'h0, 1'b1), 1'b1);
    $display("pipeline and reset done");
  endtask : t_pipe

  initial begin
    sys_rst = 1'b1;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    #1 check(32'h00000000, '0, 1'b1);
    t_pipe;
    t_legacy_full;
    t_legacy_limited;
    t_indep;
    t_classes;
    t_calls;
    report_and_stop;
  end

  // Tests need well under 1000 cycles
  initial begin
    #200000;
    n_fail++;
    $display("wrong value at %0t: watchdog expired", $time);
    report_and_stop;
  end
endmodule : test_fp_and_primary_opcode_decoder
`default_nettype wire
